// [hk_skip_pkg.sv]
// constants shared by the housekeeping cycle skip scheduler and its packet parser
package hk_skip_pkg;
    // telecommand header field values
    localparam logic [6:0] TC_APID = 7'h47;
    localparam logic [3:0] TC_CATEGORY = 4'hc;
    localparam logic [15:0] TC_LENGTH = 16'h0007;
    localparam logic [7:0] TC_TYPE = 8'hc0;
    localparam logic [7:0] TC_SUBTYPE = 8'h16;
    localparam logic [7:0] TC_PAD = 8'h00;
    // byte positions inside the packet
    localparam logic [3:0] IDX_ID_HI = 4'h0;
    localparam logic [3:0] IDX_ID_LO = 4'h1;
    localparam logic [3:0] IDX_LEN_HI = 4'h4;
    localparam logic [3:0] IDX_LEN_LO = 4'h5;
    localparam logic [3:0] IDX_TYPE = 4'h7;
    localparam logic [3:0] IDX_SUBTYPE = 4'h8;
    localparam logic [3:0] IDX_PAD = 4'h9;
    localparam logic [3:0] IDX_CNT_HI = 4'ha;
    localparam logic [3:0] IDX_CNT_LO = 4'hb;
    localparam logic [3:0] IDX_LAST = 4'hd;
    localparam logic [3:0] IDX_OVF = 4'he;
    // timing
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned HK_CYCLE_MS = 11200;
    localparam logic [31:0] HK_CYCLE_CLKS = 32'(HK_CYCLE_MS * (CLK_HZ / 1000));
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SKIP_COUNT = 8'h08;
    localparam logic [7:0] REG_SKIPPED = 8'h0c;
    localparam logic [7:0] REG_TC_STATS = 8'h10;
    // field positions and reset values
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam int ST_COLLECT_BIT = 0;
    localparam int ST_SKIP_BIT = 1;
    localparam int ST_BOOT_BIT = 2;
    localparam logic [15:0] SKIP_COUNT_RESET = 16'h0000;
    // scheduler states
    typedef enum logic [1:0] {SCH_BOOT, SCH_COLLECT, SCH_SKIP} sched_state_t;
endpackage : hk_skip_pkg

// [tc_cmd_if.sv]
// carrier for a decoded cycle-skip command from the parser to the scheduler
`timescale 1ns/100ps
interface tc_cmd_if;
    logic valid;
    logic reject;
    logic [15:0] count;
    modport src (output valid, output reject, output count);
    modport dst (input valid, input reject, input count);
endinterface : tc_cmd_if

// [tc_skip_parser.sv]
// byte-serial parser that recognises the housekeeping cycle skip command
`timescale 1ns/100ps
module tc_skip_parser (
    input wire logic clk_i,              // system clock
    input wire logic rst_i,              // synchronous reset, active high
    input wire logic [7:0] tc_byte_i,    // packet byte
    input wire logic tc_valid_i,         // byte strobe
    input wire logic tc_last_i,          // last byte of packet
    tc_cmd_if.src cmd                    // decoded command
);
    logic [3:0] idx_reg, idx_next;
    logic ok_reg, ok_next;
    logic [15:0] cnt_reg, cnt_next;
    logic valid_reg, valid_next;
    logic reject_reg, reject_next;

    // field check per byte position; checksum and sender-owned fields are not judged
    function automatic logic field_ok(input logic [3:0] idx, input logic [7:0] b);
        unique case (idx)
            hk_skip_pkg::IDX_ID_HI: field_ok = (b[2:0] == hk_skip_pkg::TC_APID[6:4]);
            hk_skip_pkg::IDX_ID_LO: field_ok = (b == {hk_skip_pkg::TC_APID[3:0], hk_skip_pkg::TC_CATEGORY});
            hk_skip_pkg::IDX_LEN_HI: field_ok = (b == hk_skip_pkg::TC_LENGTH[15:8]);
            hk_skip_pkg::IDX_LEN_LO: field_ok = (b == hk_skip_pkg::TC_LENGTH[7:0]);
            hk_skip_pkg::IDX_TYPE: field_ok = (b == hk_skip_pkg::TC_TYPE);
            hk_skip_pkg::IDX_SUBTYPE: field_ok = (b == hk_skip_pkg::TC_SUBTYPE);
            hk_skip_pkg::IDX_PAD: field_ok = (b == hk_skip_pkg::TC_PAD);
            hk_skip_pkg::IDX_OVF: field_ok = 1'b0;
            default: field_ok = (idx <= hk_skip_pkg::IDX_LAST);
        endcase
    endfunction : field_ok

    // byte walk; a packet of the wrong length is refused at its last byte
    always_comb begin
        idx_next = idx_reg;
        ok_next = ok_reg;
        cnt_next = cnt_reg;
        valid_next = 1'b0;
        reject_next = 1'b0;
        if (tc_valid_i) begin
            if (!field_ok(idx_reg, tc_byte_i)) begin
                ok_next = 1'b0; // R1 R4 R5 R7
            end
            if (idx_reg == hk_skip_pkg::IDX_CNT_HI) begin
                cnt_next = {tc_byte_i, cnt_reg[7:0]}; // R7
            end
            if (idx_reg == hk_skip_pkg::IDX_CNT_LO) begin
                cnt_next = {cnt_reg[15:8], tc_byte_i}; // R7
            end
            if (tc_last_i) begin
                valid_next = ok_next && (idx_reg == hk_skip_pkg::IDX_LAST); // R5
                reject_next = !valid_next;
                idx_next = hk_skip_pkg::IDX_ID_HI;
                ok_next = 1'b1;
            end else if (idx_reg != hk_skip_pkg::IDX_OVF) begin
                idx_next = idx_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idx_reg <= 4'h0;
            ok_reg <= 1'b1;
            cnt_reg <= 16'h0000;
            valid_reg <= 1'b0;
            reject_reg <= 1'b0;
        end else begin
            idx_reg <= idx_next;
            ok_reg <= ok_next;
            cnt_reg <= cnt_next;
            valid_reg <= valid_next;
            reject_reg <= reject_next;
        end
    end

    assign cmd.valid = valid_reg;
    assign cmd.reject = reject_reg;
    assign cmd.count = cnt_reg;

    AST_BAD_TYPE_REFUSED: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        tc_valid_i && !tc_last_i && idx_reg == hk_skip_pkg::IDX_TYPE && tc_byte_i != hk_skip_pkg::TC_TYPE
        |=> !ok_reg)
        else $error("wrong packet type not refused");
    AST_BAD_ID_REFUSED: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        tc_valid_i && !tc_last_i && idx_reg == hk_skip_pkg::IDX_ID_LO
        && tc_byte_i != {hk_skip_pkg::TC_APID[3:0], hk_skip_pkg::TC_CATEGORY}
        |=> !ok_reg)
        else $error("wrong process id or category not refused");
    AST_BAD_LEN_REFUSED: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        tc_valid_i && !tc_last_i && idx_reg == hk_skip_pkg::IDX_LEN_LO && tc_byte_i != hk_skip_pkg::TC_LENGTH[7:0]
        |=> !ok_reg)
        else $error("wrong length not refused");
    AST_VALID_ONLY_AT_END: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        tc_valid_i && tc_last_i && idx_reg != hk_skip_pkg::IDX_LAST |=> !valid_reg && reject_reg)
        else $error("short or long packet accepted");
    COV_ACCEPT: cover property (@(posedge clk_i) disable iff (rst_i) valid_reg);
    COV_REJECT: cover property (@(posedge clk_i) disable iff (rst_i) reject_reg);
endmodule : tc_skip_parser

// [hk_cycle_skip_scheduler.sv]
// housekeeping cycle skip scheduler with command parser and wishbone status registers
// Notes on behaviour
// R1 - command carries process id 1000111 and category 1100; others are refused
// R2 - sender fills sequence count with three zero bits and an 11-bit counter
// R3 - sender keeps a separate sequence counter per process id and category
// R4 - length field must read seven, application bytes plus five
// R5 - only packet type c0 with subtype 16 is taken as the skip command
// R6 - sender sets service version zero, checksum flag one, acknowledgement 0001
// R7 - after a zero pad byte comes one 16-bit unsigned skip count
// R8 - reset sets the skip count to zero, so every cycle collects
// R9 - an accepted count is loaded at once, not at a cycle boundary
// R10 - pattern: one collecting cycle, then N skipped cycles, repeating forever
// R11 - skipped cycles start no conversions and emit no housekeeping packet
// R12 - a count change takes effect only from the next cycle boundary
// R13 - a new count replaces the old; skipping continues until it is reached
// R14 - count below cycles already skipped makes the next cycle collect
// R15 - sender uses 65535 to suspend collection, small or zero to resume
// R16 - boundaries come from a periodic tick; one skip counter compared each boundary
`timescale 1ns/100ps
module hk_cycle_skip_scheduler #(
    parameter logic [31:0] CYCLE_CLKS = hk_skip_pkg::HK_CYCLE_CLKS // clocks per housekeeping cycle
) (
    input wire logic clk_i,              // 50 MHz system clock
    input wire logic rst_i,              // synchronous reset, active high
    input wire logic [7:0] tc_byte_i,    // telecommand byte
    input wire logic tc_valid_i,         // telecommand byte strobe
    input wire logic tc_last_i,          // last byte of telecommand packet
    input wire logic wb_cyc_i,           // wishbone cycle
    input wire logic wb_stb_i,           // wishbone strobe
    input wire logic wb_we_i,            // wishbone write enable
    input wire logic [7:0] wb_adr_i,     // wishbone byte address
    input wire logic [3:0] wb_sel_i,     // wishbone byte selects
    input wire logic [31:0] wb_dat_i,    // wishbone write data
    output logic [31:0] wb_dat_o,        // wishbone read data
    output logic wb_ack_o,               // wishbone acknowledge
    output logic conv_start_o,           // pulse: start engineering conversions
    output logic collecting_o,           // level: current cycle collects housekeeping
    output logic skipping_o,             // level: current cycle is skipped
    output logic tc_accept_o,            // pulse: skip command accepted
    output logic tc_reject_o             // pulse: packet refused
);
    tc_cmd_if cmd ();

    tc_skip_parser parser (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tc_byte_i(tc_byte_i),
        .tc_valid_i(tc_valid_i),
        .tc_last_i(tc_last_i),
        .cmd(cmd)
    );

    // ---- cycle tick divider
    logic [31:0] timer_reg, timer_next;
    logic tick_reg, tick_next;
    logic enable_reg, enable_next;

    // the divider freezes while disabled, so the scheduler holds its phase
    always_comb begin
        timer_next = timer_reg;
        tick_next = 1'b0;
        if (enable_reg) begin
            if (timer_reg == 32'h0000_0000) begin
                timer_next = CYCLE_CLKS - 32'h0000_0001; // R16
                tick_next = 1'b1; // R16
            end else begin
                timer_next = timer_reg - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else begin
            timer_reg <= timer_next;
            tick_reg <= tick_next;
        end
    end

    // ---- skip scheduler
    hk_skip_pkg::sched_state_t state_reg, state_next;
    logic [15:0] skip_count_reg, skip_count_next;
    logic [15:0] skipped_reg, skipped_next;
    logic conv_start_reg, conv_start_next;
    logic collecting_reg, collecting_next;
    logic skipping_reg, skipping_next;

    // decisions use the stored count only at a boundary, so a running cycle is never cut short
    always_comb begin
        state_next = state_reg;
        skipped_next = skipped_reg;
        skip_count_next = skip_count_reg;
        conv_start_next = 1'b0;
        if (cmd.valid) begin
            skip_count_next = cmd.count; // R9 R13
        end
        if (tick_reg) begin
            unique case (state_reg)
                hk_skip_pkg::SCH_BOOT: begin
                    state_next = hk_skip_pkg::SCH_COLLECT;
                end
                hk_skip_pkg::SCH_COLLECT: begin
                    if (skip_count_reg != 16'h0000) begin
                        state_next = hk_skip_pkg::SCH_SKIP; // R10 R12
                        skipped_next = 16'h0001;
                    end
                end
                hk_skip_pkg::SCH_SKIP: begin
                    if (skipped_reg >= skip_count_reg) begin
                        state_next = hk_skip_pkg::SCH_COLLECT; // R10 R14 R16
                        skipped_next = 16'h0000;
                    end else begin
                        skipped_next = skipped_reg + 16'h0001; // R13
                    end
                end
                default: state_next = hk_skip_pkg::SCH_BOOT; // an illegal code restarts from boot
            endcase
            conv_start_next = (state_next == hk_skip_pkg::SCH_COLLECT); // R11
        end
        collecting_next = (state_next == hk_skip_pkg::SCH_COLLECT);
        skipping_next = (state_next == hk_skip_pkg::SCH_SKIP); // R11
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= hk_skip_pkg::SCH_BOOT;
            skip_count_reg <= hk_skip_pkg::SKIP_COUNT_RESET; // R8
            skipped_reg <= 16'h0000;
            conv_start_reg <= 1'b0;
            collecting_reg <= 1'b0;
            skipping_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            skip_count_reg <= skip_count_next;
            skipped_reg <= skipped_next;
            conv_start_reg <= conv_start_next;
            collecting_reg <= collecting_next;
            skipping_reg <= skipping_next;
        end
    end

    // ---- command statistics and pulses
    logic [15:0] accept_cnt_reg, accept_cnt_next;
    logic [15:0] reject_cnt_reg, reject_cnt_next;
    logic accept_reg, reject_reg;

    // counters wrap; software only reads them, so no clear race exists
    always_comb begin
        accept_cnt_next = accept_cnt_reg + (cmd.valid ? 16'h0001 : 16'h0000);
        reject_cnt_next = reject_cnt_reg + (cmd.reject ? 16'h0001 : 16'h0000);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accept_cnt_reg <= 16'h0000;
            reject_cnt_reg <= 16'h0000;
            accept_reg <= 1'b0;
            reject_reg <= 1'b0;
        end else begin
            accept_cnt_reg <= accept_cnt_next;
            reject_cnt_reg <= reject_cnt_next;
            accept_reg <= cmd.valid;
            reject_reg <= cmd.reject;
        end
    end

    // ---- wishbone slave
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic [7:0] word_adr;

    assign word_adr = {wb_adr_i[7:2], 2'b00};

    // one wait state: ack follows one edge after the request; unmapped reads give zero
    // a write lands at the edge where the master sees ack, so a withdrawn request never writes
    always_comb begin
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        enable_next = enable_reg;
        rdat_next = 32'h0000_0000;
        if (ack_reg && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && word_adr == hk_skip_pkg::REG_CTRL) begin
            enable_next = wb_dat_i[hk_skip_pkg::CTRL_EN_BIT];
        end
        if (ack_next && !wb_we_i) begin
            unique case (word_adr)
                hk_skip_pkg::REG_CTRL: rdat_next[hk_skip_pkg::CTRL_EN_BIT] = enable_reg;
                hk_skip_pkg::REG_STATUS: begin
                    rdat_next[hk_skip_pkg::ST_COLLECT_BIT] = collecting_reg;
                    rdat_next[hk_skip_pkg::ST_SKIP_BIT] = skipping_reg;
                    rdat_next[hk_skip_pkg::ST_BOOT_BIT] = (state_reg == hk_skip_pkg::SCH_BOOT);
                end
                hk_skip_pkg::REG_SKIP_COUNT: rdat_next = {16'h0000, skip_count_reg};
                hk_skip_pkg::REG_SKIPPED: rdat_next = {16'h0000, skipped_reg};
                hk_skip_pkg::REG_TC_STATS: rdat_next = {reject_cnt_reg, accept_cnt_reg};
                default: rdat_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
            enable_reg <= hk_skip_pkg::CTRL_EN_RESET;
        end else begin
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            enable_reg <= enable_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign conv_start_o = conv_start_reg;
    assign collecting_o = collecting_reg;
    assign skipping_o = skipping_reg;
    assign tc_accept_o = accept_reg;
    assign tc_reject_o = reject_reg;

    // ---- checks
    AST_RESET_COUNT_ZERO: assert property (@(posedge clk_i) // R8
        rst_i |=> skip_count_reg == 16'h0000 && !skipping_o)
        else $error("skip count not zero after reset");
    AST_LOAD_AT_ONCE: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        cmd.valid |=> skip_count_reg == $past(cmd.count))
        else $error("accepted count not loaded next cycle");
    AST_NO_CONV_WHILE_SKIP: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        skipping_o |-> !conv_start_o && !collecting_o)
        else $error("conversion started in skipped cycle");
    AST_COLLECT_THEN_SKIP: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        tick_reg && state_reg == hk_skip_pkg::SCH_COLLECT && skip_count_reg != 16'h0000
        |=> skipping_o && skipped_reg == 16'h0001)
        else $error("nonzero count did not start skipping");
    AST_COLLECT_REPEAT: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        tick_reg && state_reg == hk_skip_pkg::SCH_COLLECT && skip_count_reg == 16'h0000
        |=> conv_start_o && collecting_o)
        else $error("zero count did not collect every cycle");
    AST_SKIP_DONE_COLLECT: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        tick_reg && state_reg == hk_skip_pkg::SCH_SKIP && skipped_reg >= skip_count_reg
        |=> conv_start_o && collecting_o && skipped_reg == 16'h0000)
        else $error("skip run not ended by collecting cycle");
    AST_SKIP_CONTINUE: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        tick_reg && state_reg == hk_skip_pkg::SCH_SKIP && skipped_reg < skip_count_reg
        |=> skipping_o && skipped_reg == $past(skipped_reg) + 16'h0001)
        else $error("skip run ended early");
    AST_BOUNDARY_ONLY: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        !tick_reg |=> $stable(state_reg) && $stable(skipped_reg) && !conv_start_o)
        else $error("schedule moved between boundaries");
    AST_CONV_PULSE: assert property (@(posedge clk_i) disable iff (rst_i) // R16
        conv_start_o |=> !conv_start_o)
        else $error("conversion start longer than one cycle");
    AST_COUNT_HELD: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        !cmd.valid |=> $stable(skip_count_reg))
        else $error("skip count changed without a command");
    AST_START_ONLY_COLLECT: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        conv_start_o |-> collecting_o)
        else $error("conversion start outside a collecting cycle");
    COV_ENTER_SKIP: cover property (@(posedge clk_i) disable iff (rst_i) collecting_o ##1 skipping_o);
    COV_LEAVE_SKIP: cover property (@(posedge clk_i) disable iff (rst_i) skipping_o ##1 conv_start_o);
    COV_CMD_WHILE_SKIP: cover property (@(posedge clk_i) disable iff (rst_i) skipping_o && cmd.valid);
endmodule : hk_cycle_skip_scheduler

// [tc_source.sv]
// telecommand source model that frames cycle-skip packets byte by byte
`timescale 1ns/100ps
module tc_source (
    input wire logic clk_i,        // system clock
    output logic [7:0] tc_byte_o,  // packet byte
    output logic tc_valid_o,       // byte strobe
    output logic tc_last_o         // last byte marker
);
    logic [10:0] seq_cnt [0:2047]; // one-up counter per process id and category

    // idle lines at time zero, counters start at zero
    initial begin
        tc_byte_o = 8'h00;
        tc_valid_o = 1'b0;
        tc_last_o = 1'b0;
        foreach (seq_cnt[i]) seq_cnt[i] = 11'h000;
    end

    // bad_idx flips bit 0 of one byte to provoke a refusal; -1 sends a good packet
    task automatic send(input logic [6:0] apid, input logic [3:0] cat, input logic [15:0] cnt, input int bad_idx);
        logic [7:0] pkt [0:13];
        logic [10:0] key;
        key = {apid, cat};
        pkt[0] = {3'h0, 1'b1, 1'b1, apid[6:4]};
        pkt[1] = {apid[3:0], cat};
        pkt[2] = {2'h3, 3'h0, seq_cnt[key][10:8]}; // ground source marker
        pkt[3] = seq_cnt[key][7:0];
        pkt[4] = 8'h00;
        pkt[5] = 8'h07; // two data bytes plus five
        pkt[6] = {3'h0, 1'b1, 4'h1}; // version, checksum flag, acceptance ack
        pkt[7] = 8'hc0;
        pkt[8] = 8'h16;
        pkt[9] = 8'h00;
        pkt[10] = cnt[15:8]; // count sent high byte first
        pkt[11] = cnt[7:0];
        pkt[12] = 8'h00; // checksum is not judged by the block
        pkt[13] = 8'h00;
        if (bad_idx >= 0) pkt[bad_idx] = pkt[bad_idx] ^ 8'h01;
        seq_cnt[key] = seq_cnt[key] + 11'h001;
        for (int i = 0; i < 14; i++) begin
            @(posedge clk_i);
            tc_byte_o <= pkt[i];
            tc_valid_o <= 1'b1;
            tc_last_o <= (i == 13);
        end
        @(posedge clk_i);
        tc_byte_o <= ~pkt[13]; // released line must not show a stale byte
        tc_valid_o <= 1'b0;
        tc_last_o <= 1'b0;
    endtask : send
endmodule : tc_source

// [hk_cycle_skip_scheduler_tb_top.sv]
// self-checking bench for the housekeeping cycle skip scheduler
`timescale 1ns/100ps
module hk_cycle_skip_scheduler_tb_top;
    localparam int CYC = 40; // short cycle: a whole packet fits well inside one
    localparam int LIMIT = 20000;
    logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, tc_valid, tc_last;
    logic conv_start, collecting, skipping, tc_accept, tc_reject;
    logic [7:0] wb_adr, tc_byte;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat, wb_rdat;
    int errors = 0, checks = 0, cyc_cnt = 0, last_start = 0, gap_prev = 0, skip_run = 0, skips_prev = 0;
    int n_starts = 0;

    hk_cycle_skip_scheduler #(.CYCLE_CLKS(32'h28)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .tc_byte_i(tc_byte),
        .tc_valid_i(tc_valid), .tc_last_i(tc_last), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .conv_start_o(conv_start), .collecting_o(collecting), .skipping_o(skipping),
        .tc_accept_o(tc_accept), .tc_reject_o(tc_reject));
    tc_source tc_u (.clk_i(clk_i), .tc_byte_o(tc_byte), .tc_valid_o(tc_valid), .tc_last_o(tc_last));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // watch the schedule: spacing of collecting starts and skipped clocks between them
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (conv_start === 1'b1) begin
            gap_prev = cyc_cnt - last_start;
            skips_prev = skip_run;
            skip_run = 0;
            last_start = cyc_cnt;
            n_starts++;
        end else if (skipping === 1'b1) skip_run++;
        if (cyc_cnt == LIMIT) begin
            errors++;
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // waits for ack as long as it takes; only the bench timeout ends a hang
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wdat, output logic [31:0] rdat);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'hf;
        wb_adr <= adr;
        wb_wdat <= wdat;
        @(posedge clk_i);
        while (wb_ack !== 1'b1) begin
            @(posedge clk_i);
        end
        rdat = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input string what);
        logic [31:0] d;
        wb(1'b0, adr, 32'h0, d);
        chk(what, d, exp);
    endtask : rdchk

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        wb(1'b1, adr, dat, d);
    endtask : wr

    // send one packet and look for exactly one answer pulse of the right kind
    task automatic cmd(input logic [15:0] cnt, input int bad);
        int a;
        int r;
        a = 0;
        r = 0;
        tc_u.send(7'h47, 4'hc, cnt, bad);
        repeat (6) begin
            @(negedge clk_i);
            if (tc_accept === 1'b1) a++;
            if (tc_reject === 1'b1) r++;
        end
        chk("accept_pulses", a, (bad < 0) ? 1 : 0);
        chk("reject_pulses", r, (bad < 0) ? 0 : 1);
    endtask : cmd

    task automatic wstart;
        int n0;
        int k;
        n0 = n_starts;
        k = 0;
        while (n_starts == n0 && k < 10 * CYC) begin
            @(negedge clk_i);
            k++;
        end
        chk("start_seen", k < 10 * CYC, 1'b1);
    endtask : wstart

    task automatic at(input int t);
        repeat (t - (cyc_cnt - last_start)) @(negedge clk_i);
    endtask : at

    task automatic t_reset;
        rdchk(hk_skip_pkg::REG_SKIP_COUNT, 32'h0, "skip_count_reset");
        wstart();
        wstart();
        chk("gap_default", gap_prev, CYC);
        chk("skips_default", skips_prev, 0);
    endtask : t_reset

    task automatic t_load;
        wstart();
        at(5);
        cmd(16'h0002, -1);
        rdchk(hk_skip_pkg::REG_SKIP_COUNT, 32'h2, "skip_count_now");
        chk("collect_kept", collecting, 1'b1);
        wstart();
        chk("gap_n2", gap_prev, 3 * CYC);
        chk("skip_clocks", skips_prev, 2 * CYC);
        wstart();
        chk("gap_n2_again", gap_prev, 3 * CYC);
    endtask : t_load

    task automatic t_raise;
        wstart();
        at(CYC + 5);
        cmd(16'h0005, -1);
        wstart();
        chk("gap_raised", gap_prev, 6 * CYC);
    endtask : t_raise

    task automatic t_lower;
        at(3 * CYC + 5);
        cmd(16'h0001, -1);
        rdchk(hk_skip_pkg::REG_SKIPPED, 32'h3, "skipped_before_lower");
        wstart();
        chk("gap_lowered", gap_prev, 4 * CYC);
        wstart();
        chk("gap_new_count", gap_prev, 2 * CYC);
    endtask : t_lower

    task automatic t_suspend;
        wstart();
        at(5);
        cmd(16'hffff, -1);
        at(2 * CYC + 5);
        cmd(16'h0000, -1);
        wstart();
        chk("gap_resume", gap_prev, 3 * CYC);
        wstart();
        chk("gap_zero", gap_prev, CYC);
    endtask : t_suspend

    // corrupt process id, category, length, type, subtype and pad in turn
    task automatic t_refuse;
        int idx [6] = '{0, 1, 5, 7, 8, 9};
        foreach (idx[i]) begin
            cmd(16'h00aa, idx[i]);
            rdchk(hk_skip_pkg::REG_SKIP_COUNT, 32'h0, "count_after_refusal");
        end
        cmd(16'h1234, -1);
        rdchk(hk_skip_pkg::REG_SKIP_COUNT, 32'h1234, "count_byte_order");
        cmd(16'h0000, -1);
        rdchk(hk_skip_pkg::REG_TC_STATS, {16'h0006, 16'h0007}, "tc_stats");
    endtask : t_refuse

    // restart in mid-run with a nonzero count: the count returns to zero and the status reads collecting
    task automatic t_restart;
        cmd(16'h0003, -1);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(hk_skip_pkg::REG_SKIP_COUNT, 32'h0, "count_after_restart");
        rdchk(hk_skip_pkg::REG_STATUS, 32'h1, "status_collect");
    endtask : t_restart

    task automatic t_regs;
        int n0;
        rdchk(8'h20, 32'h0, "unmapped_read");
        wr(hk_skip_pkg::REG_SKIP_COUNT, 32'h0000_4321);
        rdchk(hk_skip_pkg::REG_SKIP_COUNT, 32'h0, "ro_write_ignored");
        rdchk(hk_skip_pkg::REG_CTRL, 32'h1, "ctrl_reset");
        wr(hk_skip_pkg::REG_CTRL, 32'h0);
        repeat (4) @(negedge clk_i); // a start already in flight lands before counting
        n0 = n_starts;
        repeat (3 * CYC) @(negedge clk_i);
        chk("frozen_starts", n_starts - n0, 0);
        wr(hk_skip_pkg::REG_CTRL, 32'h1);
        wstart();
    endtask : t_regs

    task automatic end_sim;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim

    // reset held for 20 clocks, then the scenarios in order
    initial begin
        rst_i = 1'b1;
        {wb_cyc, wb_stb, wb_we} = 3'h0;
        wb_adr = 8'h00;
        wb_sel = 4'hf;
        wb_wdat = 32'h0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_load();
        t_raise();
        t_lower();
        t_suspend();
        t_refuse();
        t_restart();
        t_regs();
        end_sim();
    end
endmodule : hk_cycle_skip_scheduler_tb_top
